// [rtl/icd_defines.svh]
// Purpose: offsets, field positions, reset values and counts of the capture unit
// Assumes: included by its bare name wherever a constant is needed
// Notes: byte addresses on the register bus; each channel owns a 16-byte window
`ifndef ICD_DEFINES_SVH
`define ICD_DEFINES_SVH

// register window
`define ICD_MAP_END 8'h20
`define ICD_EVEN_BIT 4
`define ICD_OFS_CTRL1 4'h0
`define ICD_OFS_CTRL2 4'h4
`define ICD_OFS_BUF 4'h8
`define ICD_OFS_CNT 4'hC

// capture_control_one fields
`define ICD_TSEL_LSB 10
`define ICD_ICI_LSB 5
`define ICD_OV_BIT 4
`define ICD_BNE_BIT 3
`define ICD_ICM_LSB 0
`define ICD_CTRL1_WMASK 16'h1C67
`define ICD_CTRL1_RST 16'h0000

// capture_control_two fields
`define ICD_CASC_BIT 8
`define ICD_TRIG_BIT 7
`define ICD_TSTAT_BIT 6
`define ICD_SSEL_LSB 0
`define ICD_CTRL2_WMASK 16'h019F
`define ICD_CTRL2_RST 16'h000D

// sources and counts
`define ICD_TSEL_SYSCLK 3'h7
`define ICD_SYNC_VALID_MASK 32'h7FFC_FFFE
`define ICD_PRE4_LAST 4'h3
`define ICD_PRE16_LAST 4'hF
`define ICD_CNT_MAX 16'hFFFF
`define ICD_FIFO_DEPTH 4
`define ICD_RESP_OKAY 2'h0
`define ICD_RESP_SLVERR 2'h2

`endif

// [rtl/icd_pkg.sv]
// Purpose: types shared by the capture unit files
// Assumes: constants live in icd_defines.svh
// Notes: enum codes match the register encodings
package icd_pkg;
  typedef logic [15:0] icd_word_t;

  typedef enum logic [2:0] {
    ICD_CAP_OFF = 3'h0,
    ICD_CAP_EVERY = 3'h1,
    ICD_CAP_FALL = 3'h2,
    ICD_CAP_RISE = 3'h3,
    ICD_CAP_DIV4 = 3'h4,
    ICD_CAP_DIV16 = 3'h5,
    ICD_CAP_UNUSED = 3'h6,
    ICD_CAP_WAKE = 3'h7
  } icd_cap_mode_e;

  // {trigger_mode_select, source nonzero}
  typedef enum logic [1:0] {
    ICD_RUN_FREE = 2'h0,
    ICD_RUN_SYNC = 2'h1,
    ICD_RUN_SWTRIG = 2'h2,
    ICD_RUN_HWTRIG = 2'h3
  } icd_run_mode_e;
endpackage : icd_pkg

// [rtl/icd_fifo_if.sv]
// Purpose: link between a capture channel and its capture store
// Assumes: one clock and synchronous reset
// Notes: head shows the oldest entry while not empty
`timescale 1ns/1ns
`default_nettype none
interface icd_fifo_if (
  input wire logic clk,
  input wire logic rst
);
  import icd_pkg::*;
  logic push;
  logic pop;
  icd_word_t wdata;
  icd_word_t head;
  logic full;
  logic empty;

  modport ctrl (input clk, input rst, output push, output pop, output wdata, input head, input full, input empty);
  modport store (input clk, input rst, input push, input pop, input wdata, output head, output full, output empty);
endinterface : icd_fifo_if
`default_nettype wire

// [rtl/icd_capture_fifo.sv]
// Purpose: four-entry store of captured counter values
// Assumes: push when full is dropped; the caller flags the overflow
// Notes: pop when empty is ignored
`timescale 1ns/1ns
`default_nettype none
`include "icd_defines.svh"
module icd_capture_fifo (
  icd_fifo_if.store bus
);
  import icd_pkg::*;

  icd_word_t mem_reg [`ICD_FIFO_DEPTH];
  logic [1:0] wp_reg;
  logic [1:0] rp_reg;
  logic [2:0] cnt_reg;
  logic do_push;
  logic do_pop;

  // accept only what fits, release only what is held
  assign bus.full = (cnt_reg == 3'(`ICD_FIFO_DEPTH));
  assign bus.empty = (cnt_reg == 3'h0);
  assign do_push = bus.push & ~bus.full;
  assign do_pop = bus.pop & ~bus.empty;
  assign bus.head = mem_reg[rp_reg];

  // one storage word per entry
  for (genvar e = 0; e < `ICD_FIFO_DEPTH; e++) begin : g_ent
    always_ff @(posedge bus.clk) begin
      if (bus.rst) begin
        mem_reg[e] <= 16'h0000;
      end else if (do_push && (wp_reg == 2'(e))) begin
        mem_reg[e] <= bus.wdata;
      end
    end
  end

  // pointers and fill level
  always_ff @(posedge bus.clk) begin
    if (bus.rst) begin
      wp_reg <= 2'h0;
      rp_reg <= 2'h0;
      cnt_reg <= 3'h0;
    end else begin
      wp_reg <= wp_reg + {1'b0, do_push};
      rp_reg <= rp_reg + {1'b0, do_pop};
      cnt_reg <= cnt_reg + {2'h0, do_push} - {2'h0, do_pop};
    end
  end
endmodule : icd_capture_fifo
`default_nettype wire

// [rtl/icd_capture_pair.sv]
// Purpose: pair of input capture channels with dedicated counters, AXI4-Lite registers
// Assumes: all inputs synchronous to REF_CLK; tick inputs are one-cycle count enables
// Notes: channel 0 is the odd module (low half), channel 1 the even module (high half)
// Notes on behaviour
// - free running counter counts selected ticks and wraps from FFFF to 0000
// - each qualifying capture event pushes the present counter value
// - capture store holds four values per channel
// - synchronous mode counts while the sync source is enabled; sync events clear the counter
// - trigger mode holds the counter clear until the chosen source fires
// - zero source and clear trigger bit runs free; nonzero picks sync or trigger
// - zero source with trigger bit set waits for software to set armed status
// - six time base choices and twenty-eight trigger or sync sources per channel
// - capture on rising, every edge, every fourth or sixteenth rising edge
// - interrupt on every capture or every Nth, apart from edge choice
// - cascade: odd is low half, even is high half, low wrap bumps high
// - in cascade the even module follows the odd module synchronously
// - in cascade the odd module's count, trigger and mode fields govern
// - synchronous cascade keeps both counters reset until sync source enabled
// - not-empty flag shows waiting values and clears when all are read
// - mode field: off, every edge, falling, rising, 4th, 16th, unused, wake
// - interrupt after 1st to 4th capture; ignored in every-edge mode
// - time base 111 is system clock, 000 to 100 timers, others reserved
// - read-only overflow flag reports a lost capture
//
// Chosen here: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "icd_defines.svh"
module icd_capture_pair (
  input wire logic REF_CLK,
  input wire logic SRST,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  output logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  input wire logic [1:0] CAPTURE_INPUT_PIN,
  input wire logic [4:0] TIMEBASE_TICK,
  input wire logic [31:0] SYNC_EVENT,
  input wire logic [31:0] SYNC_SOURCE_ENABLED,
  output logic [1:0] CAPTURE_IRQ
);
  import icd_pkg::*;

  // bus slave state
  logic aw_held_reg;
  logic [7:0] aw_addr_reg;
  logic w_held_reg;
  logic [15:0] w_data_reg;
  logic [1:0] w_strb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;

  // per channel state, index 0 odd, 1 even
  logic [1:0][15:0] ctrl1_reg;
  logic [1:0][15:0] ctrl2_reg;
  logic [1:0] trig_armed_reg;
  logic [1:0][15:0] capture_counter_reg;
  logic [1:0] pin_d_reg;
  logic [1:0][3:0] pre_reg;
  logic [1:0][1:0] ici_cnt_reg;
  logic [1:0] ovf_reg;
  logic [1:0] irq_reg;

  // per channel combinational terms
  logic [1:0] tick_own;
  logic [1:0] run_own;
  logic [1:0] clr_own;
  logic [1:0] cap_own;
  logic [1:0] irq_own;
  logic [1:0] clr_eff;
  logic [1:0] inc_eff;
  logic [1:0] cap_eff;
  logic [1:0] roll;
  logic [1:0] follow;
  logic [1:0] wr_c1;
  logic [1:0] wr_c2;
  logic [1:0] rd_pop;
  logic [1:0] fifo_full;
  logic [1:0] fifo_empty;
  logic [1:0][15:0] fifo_head;
  logic [1:0][15:0] c1_rb;
  logic [1:0][15:0] c2_rb;

  logic cascade_on;
  logic do_write;
  logic wr_ok;
  logic ar_take;
  logic rd_ok;
  logic rd_ch;
  logic [3:0] rd_off;
  logic [15:0] wmask16;
  logic [15:0] rd_word;

  // write channel: address and data are taken independently, then joined
  assign S_AXI_AWREADY = ~aw_held_reg & ~bvalid_reg;
  assign S_AXI_WREADY = ~w_held_reg & ~bvalid_reg;
  assign do_write = aw_held_reg & w_held_reg & ~bvalid_reg;
  assign wr_ok = (aw_addr_reg < `ICD_MAP_END);
  assign wmask16 = {{8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
  assign S_AXI_BVALID = bvalid_reg;
  assign S_AXI_BRESP = bresp_reg;

  // read channel: one read in flight, answer the edge after the address is taken
  assign S_AXI_ARREADY = ~rvalid_reg;
  assign ar_take = S_AXI_ARVALID & ~rvalid_reg;
  assign rd_ok = (S_AXI_ARADDR < `ICD_MAP_END);
  assign rd_ch = S_AXI_ARADDR[`ICD_EVEN_BIT];
  assign rd_off = S_AXI_ARADDR[3:0];
  assign S_AXI_RVALID = rvalid_reg;
  assign S_AXI_RDATA = rdata_reg;
  assign S_AXI_RRESP = rresp_reg;

  // cascade only when both modules ask for it
  assign cascade_on = ctrl2_reg[0][`ICD_CASC_BIT] & ctrl2_reg[1][`ICD_CASC_BIT];

  // read selection
  assign rd_word = (rd_off == `ICD_OFS_CTRL1) ? c1_rb[rd_ch] :
                   (rd_off == `ICD_OFS_CTRL2) ? c2_rb[rd_ch] :
                   (rd_off == `ICD_OFS_BUF) ? fifo_head[rd_ch] :
                   (rd_off == `ICD_OFS_CNT) ? capture_counter_reg[rd_ch] : 16'h0000;

  // write half of the bus slave
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_held_reg <= 1'b0;
      w_data_reg <= 16'h0000;
      w_strb_reg <= 2'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `ICD_RESP_OKAY;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= S_AXI_AWADDR;
      end else if (do_write) begin
        aw_held_reg <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_held_reg <= 1'b1;
        w_data_reg <= S_AXI_WDATA[15:0];
        w_strb_reg <= S_AXI_WSTRB[1:0];
      end else if (do_write) begin
        w_held_reg <= 1'b0;
      end
      if (do_write) begin
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_ok ? `ICD_RESP_OKAY : `ICD_RESP_SLVERR;
      end else if (S_AXI_BREADY) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // read half of the bus slave; reading a buffer port pops it
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= `ICD_RESP_OKAY;
    end else if (ar_take) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_ok ? {16'h0000, rd_word} : 32'h0000_0000;
      rresp_reg <= rd_ok ? `ICD_RESP_OKAY : `ICD_RESP_SLVERR;
    end else if (S_AXI_RREADY) begin
      rvalid_reg <= 1'b0;
    end
  end

  for (genvar g = 0; g < 2; g++) begin : g_ch
    icd_word_t cnt_w;
    logic [2:0] tsel;
    logic [1:0] captures_per_interrupt;
    logic [4:0] ssel;
    logic [7:0] tick_vec;
    logic [31:0] sev_vec;
    logic sev;
    logic son;
    logic rise;
    logic fall;
    logic hw_arm;
    logic sw_arm_wr;
    logic cap_raw;
    logic ici_hit;
    logic [1:0] gv; // channel whose mode fields govern this one
    icd_cap_mode_e mode;
    icd_run_mode_e run_mode;

    icd_fifo_if fif (.clk(REF_CLK), .rst(SRST));

    icd_capture_fifo u_fifo (
      .bus(fif.store)
    );

    // in cascade the even module takes the odd module's mode fields
    assign follow[g] = (g != 0) & cascade_on;
    assign gv = follow[g] ? 2'h0 : 2'(g);
    assign tsel = ctrl1_reg[g][`ICD_TSEL_LSB +: 3];
    assign captures_per_interrupt = ctrl1_reg[gv][`ICD_ICI_LSB +: 2];
    assign mode = icd_cap_mode_e'(ctrl1_reg[gv][`ICD_ICM_LSB +: 3]);
    assign ssel = ctrl2_reg[g][`ICD_SSEL_LSB +: 5];

    // time base: five timer ticks, two reserved codes, system clock always ticks
    assign tick_vec = {1'b1, 2'h0, TIMEBASE_TICK};
    assign tick_own[g] = tick_vec[tsel];

    // sync or trigger source; reserved and zero codes never fire
    assign sev_vec = SYNC_EVENT & `ICD_SYNC_VALID_MASK;
    assign sev = sev_vec[ssel];
    assign son = SYNC_SOURCE_ENABLED[ssel];
    assign run_mode = icd_run_mode_e'({ctrl2_reg[g][`ICD_TRIG_BIT], |ssel});

    // hardware arms on the source event; software may also set it
    assign hw_arm = (run_mode == ICD_RUN_HWTRIG) & sev;
    assign sw_arm_wr = wr_c2[g] & w_strb_reg[0];

    // whether the counter may run in this channel's own setting
    always_comb begin
      unique case (run_mode)
        ICD_RUN_FREE: run_own[g] = 1'b1;
        ICD_RUN_SYNC: run_own[g] = son;
        ICD_RUN_SWTRIG: run_own[g] = trig_armed_reg[g];
        ICD_RUN_HWTRIG: run_own[g] = trig_armed_reg[g];
      endcase
    end

    // held clear when stopped, off, unused, or on a sync event
    assign clr_own[g] = ~run_own[g] | (mode == ICD_CAP_OFF) | (mode == ICD_CAP_UNUSED) |
                        ((run_mode == ICD_RUN_SYNC) & sev);

    // the even half follows the odd half's clear, wraps and events
    assign clr_eff[g] = follow[g] ? clr_own[0] : clr_own[g];
    assign inc_eff[g] = follow[g] ? roll[0] : tick_own[g];
    assign cap_eff[g] = follow[g] ? cap_own[0] : cap_own[g];
    assign roll[g] = inc_eff[g] & ~clr_eff[g] & (capture_counter_reg[g] == `ICD_CNT_MAX);
    assign cnt_w = capture_counter_reg[g];

    // pin edges, the pin being synchronous already
    assign rise = CAPTURE_INPUT_PIN[g] & ~pin_d_reg[g];
    assign fall = ~CAPTURE_INPUT_PIN[g] & pin_d_reg[g];

    // capture qualification by mode
    always_comb begin
      unique case (mode)
        ICD_CAP_EVERY: cap_raw = rise | fall;
        ICD_CAP_FALL: cap_raw = fall;
        ICD_CAP_RISE: cap_raw = rise;
        ICD_CAP_DIV4: cap_raw = rise & (pre_reg[g] == `ICD_PRE4_LAST);
        ICD_CAP_DIV16: cap_raw = rise & (pre_reg[g] == `ICD_PRE16_LAST);
        default: cap_raw = 1'b0; // off, unused, wake: no capture
      endcase
    end
    assign cap_own[g] = cap_raw & run_own[g];

    // interrupt: every event in every-edge mode, else every Nth; wake mode on rise
    assign ici_hit = (ici_cnt_reg[g] == captures_per_interrupt);
    assign irq_own[g] = (mode == ICD_CAP_WAKE) ? rise :
                        (mode == ICD_CAP_EVERY) ? cap_own[g] : (cap_own[g] & ici_hit);

    // store hookup; overflow drops the value inside the store
    assign fif.push = cap_eff[g];
    assign fif.wdata = cnt_w;
    assign fif.pop = rd_pop[g];
    assign fifo_full[g] = fif.full;
    assign fifo_empty[g] = fif.empty;
    assign fifo_head[g] = fif.head;
    assign rd_pop[g] = ar_take & rd_ok & (rd_ch == 1'(g)) & (rd_off == `ICD_OFS_BUF);

    // register write decode and readback
    assign wr_c1[g] = do_write & wr_ok & (aw_addr_reg[`ICD_EVEN_BIT] == 1'(g)) &
                      (aw_addr_reg[3:0] == `ICD_OFS_CTRL1);
    assign wr_c2[g] = do_write & wr_ok & (aw_addr_reg[`ICD_EVEN_BIT] == 1'(g)) &
                      (aw_addr_reg[3:0] == `ICD_OFS_CTRL2);
    assign c1_rb[g] = ctrl1_reg[g] | ({15'h0000, ovf_reg[g]} << `ICD_OV_BIT) |
                      ({15'h0000, ~fifo_empty[g]} << `ICD_BNE_BIT);
    assign c2_rb[g] = ctrl2_reg[g] | ({15'h0000, trig_armed_reg[g]} << `ICD_TSTAT_BIT);

    // control registers, byte lanes honoured
    always_ff @(posedge REF_CLK) begin
      if (SRST) begin
        ctrl1_reg[g] <= `ICD_CTRL1_RST;
        ctrl2_reg[g] <= `ICD_CTRL2_RST;
      end else begin
        if (wr_c1[g]) begin
          ctrl1_reg[g] <= (ctrl1_reg[g] & ~(wmask16 & `ICD_CTRL1_WMASK)) |
                          (w_data_reg & wmask16 & `ICD_CTRL1_WMASK);
        end
        if (wr_c2[g]) begin
          ctrl2_reg[g] <= (ctrl2_reg[g] & ~(wmask16 & `ICD_CTRL2_WMASK)) |
                          (w_data_reg & wmask16 & `ICD_CTRL2_WMASK);
        end
      end
    end

    // armed status: hardware set wins over a software clear in the same cycle
    always_ff @(posedge REF_CLK) begin
      if (SRST) begin
        trig_armed_reg[g] <= 1'b0;
      end else if (hw_arm) begin
        trig_armed_reg[g] <= 1'b1;
      end else if (sw_arm_wr) begin
        trig_armed_reg[g] <= w_data_reg[`ICD_TSTAT_BIT];
      end
    end

    // dedicated counter
    always_ff @(posedge REF_CLK) begin
      if (SRST) begin
        capture_counter_reg[g] <= 16'h0000;
      end else if (clr_eff[g]) begin
        capture_counter_reg[g] <= 16'h0000;
      end else if (inc_eff[g]) begin
        capture_counter_reg[g] <= capture_counter_reg[g] + 16'h0001;
      end
    end

    // edge history, prescaler and interrupt count
    always_ff @(posedge REF_CLK) begin
      if (SRST) begin
        pin_d_reg[g] <= 1'b0;
        pre_reg[g] <= 4'h0;
        ici_cnt_reg[g] <= 2'h0;
      end else begin
        pin_d_reg[g] <= CAPTURE_INPUT_PIN[g];
        if ((mode != ICD_CAP_DIV4) && (mode != ICD_CAP_DIV16)) begin
          pre_reg[g] <= 4'h0;
        end else if (rise && run_own[g]) begin
          pre_reg[g] <= cap_raw ? 4'h0 : pre_reg[g] + 4'h1;
        end
        if (mode == ICD_CAP_OFF) begin
          ici_cnt_reg[g] <= 2'h0;
        end else if (cap_own[g]) begin
          ici_cnt_reg[g] <= ici_hit ? 2'h0 : ici_cnt_reg[g] + 2'h1;
        end
      end
    end

    // overflow: a lost capture sets, a buffer read clears, set wins
    always_ff @(posedge REF_CLK) begin
      if (SRST) begin
        ovf_reg[g] <= 1'b0;
        irq_reg[g] <= 1'b0;
      end else begin
        if (cap_eff[g] && fifo_full[g]) begin
          ovf_reg[g] <= 1'b1;
        end else if (rd_pop[g]) begin
          ovf_reg[g] <= 1'b0;
        end
        // the even half stays quiet in cascade; the odd half speaks for both
        irq_reg[g] <= irq_own[g] & ~follow[g];
      end
    end
  end

  assign CAPTURE_IRQ = irq_reg;
endmodule : icd_capture_pair
`default_nettype wire

// [tb/icd_capture_pair_sva.sv]
// Purpose: bus handshake and capture interrupt checks on the capture pair ports
// Assumes: one clock, SRST synchronous active high
// Notes: bound onto every icd_capture_pair; watches outputs only against their causes
`timescale 1ns/1ns
`default_nettype none
module icd_capture_pair_sva (
  input wire logic REF_CLK,
  input wire logic SRST,
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_WREADY,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic [1:0] S_AXI_RRESP,
  input wire logic [1:0] CAPTURE_INPUT_PIN,
  input wire logic [1:0] CAPTURE_IRQ
);
  // all checks share the one clock and its reset
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (SRST);

  // handshake order on the register bus
  write_refuse_a: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
    else $error("write accepted while response pending");
  write_answer_a: assert property (S_AXI_AWVALID && S_AXI_AWREADY |-> ##[1:4] S_AXI_BVALID)
    else $error("write response missing");
  bvalid_clear_a: assert property (S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID)
    else $error("write response held after handshake");
  write_unmapped_a: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_AWADDR >= 8'h20
    |-> ##[1:4] S_AXI_BVALID && S_AXI_BRESP == 2'h2) else $error("unmapped write not refused");
  read_refuse_a: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
    else $error("read accepted while data pending");
  read_answer_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY |-> ##[1:2] S_AXI_RVALID)
    else $error("read data missing");
  rvalid_clear_a: assert property (S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID)
    else $error("read data held after handshake");
  read_unmapped_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR >= 8'h20
    |-> ##[1:2] S_AXI_RVALID && S_AXI_RRESP == 2'h2 && S_AXI_RDATA == 32'h0) else $error("bad unmapped read");
  rdata_upper_a: assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:16] == 16'h0000)
    else $error("upper read half not zero");
  // a channel 0 interrupt needs a recent pin transition behind it
  irq_cause_a: assert property ($rose(CAPTURE_IRQ[0]) |->
    $past(CAPTURE_INPUT_PIN[0], 1) != $past(CAPTURE_INPUT_PIN[0], 2) ||
    $past(CAPTURE_INPUT_PIN[0], 2) != $past(CAPTURE_INPUT_PIN[0], 3)) else $error("interrupt without pin edge");
endmodule : icd_capture_pair_sva
bind icd_capture_pair icd_capture_pair_sva u_icd_capture_pair_sva (.*);
`default_nettype wire

// [tb/icd_pulse_src.sv]
// Purpose: far side of the capture pair: pulse pin, time base ticks and sync sources
// Assumes: tasks are called just after a rising edge
// Notes: ticks only on command so counter values stay exact
`timescale 1ns/1ns
`default_nettype none
module icd_pulse_src (
  input wire logic clk,
  output logic [1:0] pin,
  output logic [4:0] tick,
  output logic [31:0] sync_ev,
  output logic [31:0] sync_en
);
  // sources start disabled so setup can finish first
  initial begin
    pin = 2'h0;
    tick = 5'h00;
    sync_ev = 32'h0;
    sync_en = 32'h0;
  end
  // full pulses on both pins, three cycles high and three low
  task automatic pulses(input int n);
    for (int i = 0; i < n; i++) begin
      pin <= 2'h3;
      repeat (3) @(posedge clk);
      pin <= 2'h0;
      repeat (3) @(posedge clk);
    end
  endtask : pulses
  // n back-to-back count enables on one time base
  task automatic ticks(input int code, input int n);
    tick[code] <= 1'b1;
    repeat (n) @(posedge clk);
    tick[code] <= 1'b0;
    @(posedge clk);
  endtask : ticks
  // one event cycle from a sync source
  task automatic sync_pulse(input int code);
    sync_ev[code] <= 1'b1;
    @(posedge clk);
    sync_ev[code] <= 1'b0;
    @(posedge clk);
  endtask : sync_pulse
  // switch a source on last, after configuration
  task automatic enable(input int code, input logic v);
    sync_en[code] <= v;
    @(posedge clk);
  endtask : enable
endmodule : icd_pulse_src
`default_nettype wire

// [tb/tb.sv]
// Purpose: self-checking bench for the capture pair over its register bus
// Assumes: response ready raised with each request; write strobes given per call
// Notes: time base code 0 gives exact counter values, code 7 where values do not matter
`timescale 1ns/1ns
`default_nettype none
module tb;
  import icd_pkg::*;
  logic REF_CLK, SRST, S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY, S_AXI_BVALID;
  logic S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID;
  logic S_AXI_BREADY, S_AXI_RREADY;
  logic [3:0] S_AXI_WSTRB;
  logic [7:0] S_AXI_AWADDR, S_AXI_ARADDR;
  logic [31:0] S_AXI_WDATA, S_AXI_RDATA, SYNC_EVENT, SYNC_SOURCE_ENABLED, d;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP, CAPTURE_INPUT_PIN, CAPTURE_IRQ, r;
  logic [4:0] TIMEBASE_TICK;
  int num_errors, check_count, irq_cnt, irq1_cnt, cyc, irq_base;
  // capture mode table: config word, status bits expected after 16 pulses, interrupt count
  logic [15:0] mode_cfg [7] = '{16'h1C61, 16'h1C02, 16'h1C23, 16'h1C64, 16'h1C05, 16'h1C06, 16'h1C07};
  logic [15:0] mode_st [7] = '{16'h0018, 16'h0018, 16'h0018, 16'h0008, 16'h0008, 16'h0000, 16'h0000};
  int mode_irq [7] = '{32, 16, 8, 1, 1, 0, 16};

  icd_capture_pair u_icd_capture_pair (.*);
  icd_pulse_src u_icd_pulse_src (.clk(REF_CLK), .pin(CAPTURE_INPUT_PIN), .tick(TIMEBASE_TICK),
    .sync_ev(SYNC_EVENT), .sync_en(SYNC_SOURCE_ENABLED));

  // 25 MHz clock
  initial begin
    REF_CLK = 1'b0;
    forever #20 REF_CLK = ~REF_CLK;
  end
  // interrupt pulse counts and run-time ceiling
  always @(posedge REF_CLK) begin
    cyc++;
    if (CAPTURE_IRQ[0] === 1'b1) irq_cnt++;
    if (CAPTURE_IRQ[1] === 1'b1) irq1_cnt++;
    if (cyc == 90000) begin
      num_errors++;
      report_and_stop();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // both write halves offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [15:0] v, input logic [3:0] s = 4'hF);
    logic done;
    done = 1'b0;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    S_AXI_BREADY <= 1'b1;
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= {16'h0000, v};
    S_AXI_WSTRB <= s;
    while (!done) begin
      @(posedge REF_CLK);
      if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
      if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
      if (S_AXI_BVALID) done = 1'b1;
    end
    S_AXI_BREADY <= 1'b0;
    @(posedge REF_CLK);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
    logic done;
    done = 1'b0;
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY <= 1'b1;
    S_AXI_ARADDR <= a;
    while (!done) begin
      @(posedge REF_CLK);
      if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
      if (S_AXI_RVALID) begin
        done = 1'b1;
        v = S_AXI_RDATA;
        resp = S_AXI_RRESP;
      end
    end
    S_AXI_RREADY <= 1'b0;
    @(posedge REF_CLK);
  endtask : rd
  task automatic rc(input logic [7:0] a, input logic [15:0] exp);
    rd(a, d, r);
    check(d, {16'h0000, exp});
  endtask : rc
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    SRST = 1'b1;
    {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_ARVALID, S_AXI_BREADY, S_AXI_RREADY, S_AXI_WSTRB} = 9'h000;
    {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA} = 48'h0;
    repeat (8) @(posedge REF_CLK);
    SRST <= 1'b0;
    @(posedge REF_CLK);
    // reset values and unmapped places
    rc(8'h00, 16'h0000);
    rc(8'h04, 16'h000D);
    rc(8'h14, 16'h000D);
    rd(8'h20, d, r);
    check({30'h0, r}, 32'h2);
    wr(8'h24, 16'h1234);
    $display("reset test done");
    // sync mode: held while source disabled, cleared by each sync event
    wr(8'h00, 16'h0003);
    u_icd_pulse_src.ticks(0, 3);
    u_icd_pulse_src.pulses(1);
    rc(8'h00, 16'h0003);
    u_icd_pulse_src.enable(13, 1'b1);
    u_icd_pulse_src.ticks(0, 3);
    u_icd_pulse_src.sync_pulse(13);
    u_icd_pulse_src.ticks(0, 2);
    rc(8'h0C, 16'h0002);
    u_icd_pulse_src.pulses(1);
    rc(8'h08, 16'h0002);
    rc(8'h00, 16'h0003);
    u_icd_pulse_src.enable(13, 1'b0);
    $display("sync test done");
    // hardware trigger from source 5, then software trigger
    wr(8'h00, 16'h0000);
    wr(8'h04, 16'h0085);
    wr(8'h00, 16'h1003);
    u_icd_pulse_src.ticks(4, 3);
    u_icd_pulse_src.pulses(1);
    rc(8'h00, 16'h1003);
    u_icd_pulse_src.sync_pulse(5);
    rc(8'h04, 16'h00C5);
    u_icd_pulse_src.ticks(4, 4);
    u_icd_pulse_src.pulses(1);
    rc(8'h08, 16'h0004);
    wr(8'h00, 16'h0000);
    wr(8'h04, 16'h0080);
    wr(8'h00, 16'h0003);
    u_icd_pulse_src.ticks(0, 2);
    u_icd_pulse_src.pulses(1);
    rc(8'h00, 16'h0003);
    wr(8'h04, 16'h00C0);
    u_icd_pulse_src.ticks(0, 2);
    u_icd_pulse_src.pulses(1);
    rc(8'h08, 16'h0002);
    $display("trigger test done");
    // free run: five captures into a four-entry store
    wr(8'h00, 16'h0000);
    wr(8'h04, 16'h0000);
    wr(8'h00, 16'h0003);
    for (int i = 0; i < 5; i++) begin
      u_icd_pulse_src.ticks(0, 1);
      u_icd_pulse_src.pulses(1);
    end
    rc(8'h00, 16'h001B);
    rc(8'h08, 16'h0001);
    rc(8'h00, 16'h000B);
    for (int i = 2; i < 5; i++) rc(8'h08, 16'(i));
    rc(8'h00, 16'h0003);
    wr(8'h00, 16'h1C00, 4'h2);
    rc(8'h00, 16'h1C03);
    $display("store test done");
    // every capture mode apart from off, and interrupt count, on the system clock base
    for (int i = 0; i < 7; i++) begin
      wr(8'h00, 16'h1C00);
      irq_base = irq_cnt;
      wr(8'h00, mode_cfg[i]);
      u_icd_pulse_src.pulses(16);
      rc(8'h00, mode_cfg[i] | mode_st[i]);
      check(irq_cnt - irq_base, mode_irq[i]);
      repeat (4) rd(8'h08, d, r);
    end
    $display("mode test done");
    // cascade: even module set first, low wrap bumps the high half
    wr(8'h00, 16'h0000);
    wr(8'h14, 16'h0100);
    wr(8'h04, 16'h0100);
    wr(8'h10, 16'h0003);
    wr(8'h00, 16'h0003);
    u_icd_pulse_src.ticks(0, 65537);
    u_icd_pulse_src.pulses(1);
    rc(8'h08, 16'h0001);
    rc(8'h18, 16'h0001);
    check(irq1_cnt, 32'h0);
    $display("cascade test done");
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
